/* File: design/sepfe_pkg.sv */
// Purpose: Shared constants and types of the serial EEPROM bus front end.
// Assumes: System clock of 20 MHz; link sampling clock is a separate domain.
// Notes: Size selection codes pick one of four array capacities.

// ============================================================================
// Package
package sepfe_pkg;

  // System clock rate in hertz.
  localparam int unsigned SYS_CLK_HZ = 20_000_000;
  // Self-timed write cycle, longest time, in microseconds (5 ms).
  localparam int unsigned TWR_US = 5000;
  // Write cycle in system clock cycles; the longest time converts exactly (100000).
  localparam int unsigned TWR_CYCLES = TWR_US * (SYS_CLK_HZ / 1_000_000);

  // Fixed type pattern in the four upper bits of the device-address word.
  localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
  // Bits in one transferred word; the ninth clock carries the acknowledge.
  localparam logic [3:0] WORD_BITS = 4'h8;

  // Array geometry of the largest capacity.
  localparam int unsigned MEM_BYTES = 2048;
  localparam int unsigned ADDR_W = 11;

  // Capacity selection codes.
  localparam logic [1:0] SZ_2K = 2'h0;
  localparam logic [1:0] SZ_4K = 2'h1;
  localparam logic [1:0] SZ_8K = 2'h2;
  localparam logic [1:0] SZ_16K = 2'h3;

  // Word address masks of each capacity (8, 9, 10 and 11 bits).
  localparam logic [10:0] ARR_MASK_2K = 11'h0ff;
  localparam logic [10:0] ARR_MASK_4K = 11'h1ff;
  localparam logic [10:0] ARR_MASK_8K = 11'h3ff;
  localparam logic [10:0] ARR_MASK_16K = 11'h7ff;

  // In-page offset masks: 8-byte pages and 16-byte pages.
  localparam logic [10:0] PAGE8_MASK = 11'h007;
  localparam logic [10:0] PAGE16_MASK = 11'h00f;

  // Reset values.
  localparam logic STANDBY_RST = 1'b1;
  localparam logic LINE_IDLE = 1'b1;

  // Link protocol states.
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_DEVADDR,
    ST_DEVACK,
    ST_WADDR,
    ST_WAACK,
    ST_WDATA,
    ST_WDACK,
    ST_RDATA,
    ST_RACK
  } sepfe_state_e;

endpackage

/* File: design/sepfe_sync.sv */
// Purpose: Three-stage input synchroniser with a two-stage agreement filter.
// Assumes: Input comes from outside the clock domain of clk.
// Notes: Output changes only when the second and third stages agree.

`timescale 1ns/100ps
`default_nettype none

// ============================================================================
// Synchroniser
module sepfe_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Asynchronous input and filtered output
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] q;
  } sepfe_sync_s;

  sepfe_sync_s sync_reg;
  sepfe_sync_s sync_next;

  // Shift the chain; a glitch shorter than one cycle never reaches q.
  always_comb begin
    sync_next = sync_reg;
    sync_next.ff1 = d;
    sync_next.ff2 = sync_reg.ff1;
    sync_next.ff3 = sync_reg.ff2;
    for (int i = 0; i < int'(W); i++) begin
      if (sync_reg.ff2[i] == sync_reg.ff3[i]) begin
        sync_next.q[i] = sync_reg.ff3[i];
      end
    end
  end

  // Register the chain.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync_reg <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign q = sync_reg.q;

endmodule

`default_nettype wire

/* File: design/sepfe_top.sv */
// Purpose: Two-wire serial EEPROM target front end with its byte array.
// Assumes: The link is oversampled on link_clk; rst_n and link_rst_n are
//   synchronous to their own clocks.
// Notes: The write cycle timer runs on sys_clk; all else on link_clk.
//
// Overview of operation
// [R1] Data line is only pulled low or released, never driven high.
// [R2] Sample data on clock rise; shift out data after clock fall.
// [R3] Write-protect high blocks every array write; low allows normal access.
// [R4] 2K: 32 pages of 8 bytes, 8-bit word address.
// [R5] 4K: 32 pages of 16 bytes, 9-bit word address.
// [R6] 8K: 64 pages of 16 bytes, 10-bit word address.
// [R7] 16K: 128 pages of 16 bytes, 11-bit word address.
// [R8] Data changes only while clock low; clock-high changes mean start/stop.
// [R9] Data falling while clock high is a start; precedes every command.
// [R10] Data rising while clock high is a stop; after a read, standby.
// [R11] Eight-bit words; device pulls data low in the ninth clock.
// [R12] Standby at power-up and after stop once internal work is done.
// [R13] Controller clocks up to nine cycles, then start; device resynchronises.
// [R14] After start, expect device-address word with type pattern 1010 on top.
// [R15] 2K compares three select bits against the three straps.
// [R16] 4K compares upper two select bits; third is a page bit.
// [R17] 8K compares upper select bit; next two are page bits.
// [R18] 16K compares no select bits; all three are page bits.
// [R19] Page bits form the top of the following word address.
// [R20] Eighth device-address bit: high reads, low writes.
// [R21] Matching address is acknowledged; mismatch gives no ack and standby.
// [R22] No address acknowledge while an internal write cycle runs.
// [R23] Word-address counter holds last accessed address plus one.
// [R24] Clock and data inputs are synchronised and filtered before edge detection.

`timescale 1ns/100ps
`default_nettype none

// ============================================================================
// Top module
module sepfe_top
  import sepfe_pkg::*;
#(
  parameter logic [1:0] SIZE_SEL = SZ_16K,
  parameter int unsigned TWR_CYC = TWR_CYCLES
) (
  // System clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Link sampling clock and reset
  input wire logic link_clk,
  input wire logic link_rst_n,
  // Two-wire bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Straps and protection
  input wire logic [2:0] chip_select_straps,
  input wire logic wp_i,
  // Status
  output logic standby
);

  // ==========================================================================
  // Decoding functions

  // Word address mask of the selected capacity.
  function automatic logic [10:0] arr_mask(input logic [1:0] sz);
    logic [10:0] m;
    m = ARR_MASK_16K;
    unique case (sz)
      SZ_2K: m = ARR_MASK_2K;
      SZ_4K: m = ARR_MASK_4K;
      SZ_8K: m = ARR_MASK_8K;
      SZ_16K: m = ARR_MASK_16K;
    endcase
    return m;
  endfunction

  // Check the device-address word against the type pattern and straps.
  function automatic logic dev_match(input logic [7:0] w, input logic [2:0] s,
                                     input logic [1:0] sz);
    logic ok;
    ok = 1'b0;
    unique case (sz)
      SZ_2K: ok = (w[3:1] == s);
      SZ_4K: ok = (w[3:2] == s[2:1]);
      SZ_8K: ok = (w[3] == s[2]);
      SZ_16K: ok = 1'b1;
    endcase
    return ok && (w[7:4] == DEV_TYPE_CODE);
  endfunction

  // Page bits carried in the select field of the device-address word.
  function automatic logic [2:0] page_hi(input logic [7:0] w, input logic [1:0] sz);
    logic [2:0] p;
    p = 3'h0;
    unique case (sz)
      SZ_2K: p = 3'h0;
      SZ_4K: p = {2'h0, w[1]};
      SZ_8K: p = {1'h0, w[2:1]};
      SZ_16K: p = w[3:1];
    endcase
    return p;
  endfunction

  // Next word address: writes roll within the page, reads over the array.
  function automatic logic [10:0] next_addr(input logic [10:0] a, input logic wr,
                                            input logic [1:0] sz);
    logic [10:0] pm;
    logic [10:0] inc;
    pm = (sz == SZ_2K) ? PAGE8_MASK : PAGE16_MASK;
    inc = 11'(a + 11'h001);
    if (wr) begin
      return (a & ~pm) | (inc & pm);
    end
    return inc & arr_mask(sz);
  endfunction

  // ==========================================================================
  // Input synchronisers

  logic scl_f;
  logic sda_f;
  logic wp_f;
  logic [2:0] strap_f;
  logic busy_f;
  logic tgl_f;

  // [R24] Pin filtering stage
  sepfe_sync #(.W(2), .RST_VAL({LINE_IDLE, LINE_IDLE})) u_sync_bus (
    .clk(link_clk),
    .rst_n(link_rst_n),
    .d({scl_i, sda_i}),
    .q({scl_f, sda_f})
  );

  // Write protect and straps are static levels, filtered the same way.
  sepfe_sync #(.W(4), .RST_VAL(4'h0)) u_sync_cfg (
    .clk(link_clk),
    .rst_n(link_rst_n),
    .d({wp_i, chip_select_straps}),
    .q({wp_f, strap_f})
  );

  // ==========================================================================
  // Link domain state

  typedef struct packed {
    sepfe_state_e st;
    logic scl_q;
    logic sda_q;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic [2:0] pg;
    logic [10:0] actr;
    logic oe;
    logic lvl;
    logic acked;
    logic dirty;
    logic wr_tgl;
    logic pend;
    logic bsy_seen;
    logic stby;
    logic we;
    logic [10:0] waddr;
    logic [7:0] wd;
  } sepfe_link_s;

  sepfe_link_s link_reg;
  sepfe_link_s link_next;

  // Byte array, sized for the largest capacity.
  logic [7:0] mem [MEM_BYTES];
  logic [7:0] rd_byte;

  logic start_ev;
  logic stop_ev;
  logic scl_rise;
  logic scl_fall;

  // [R9] Start detect
  assign start_ev = scl_f && link_reg.scl_q && link_reg.sda_q && !sda_f;
  // [R10] Stop detect
  assign stop_ev = scl_f && link_reg.scl_q && !link_reg.sda_q && sda_f;
  // [R8] Data bits only between clock edges
  assign scl_rise = scl_f && !link_reg.scl_q;
  assign scl_fall = !scl_f && link_reg.scl_q;

  // [R4] [R5] [R6] [R7] Address confined to the capacity
  assign rd_byte = mem[link_reg.actr & arr_mask(SIZE_SEL)];

  // Protocol engine of the link.
  always_comb begin
    link_next = link_reg;
    link_next.we = 1'b0;
    // [R1] Drive level stays low
    link_next.lvl = 1'b0;
    link_next.scl_q = scl_f;
    link_next.sda_q = sda_f;
    // Track the write cycle in the system domain until it ends.
    if (link_reg.pend && busy_f) begin
      link_next.bsy_seen = 1'b1;
    end
    if (link_reg.pend && link_reg.bsy_seen && !busy_f) begin
      link_next.pend = 1'b0;
      link_next.bsy_seen = 1'b0;
    end
    if (start_ev) begin
      // [R13] Resync on start
      link_next.st = ST_DEVADDR;
      link_next.cnt = 4'h0;
      link_next.sh = 8'h00;
      link_next.oe = 1'b0;
    end else if (stop_ev) begin
      // [R12] Stop then commit
      link_next.st = ST_IDLE;
      link_next.oe = 1'b0;
      if (link_reg.dirty) begin
        link_next.dirty = 1'b0;
        link_next.wr_tgl = !link_reg.wr_tgl;
        link_next.pend = 1'b1;
        link_next.bsy_seen = 1'b0;
      end
    end else begin
      unique case (link_reg.st)
        ST_IDLE: begin
          link_next.oe = 1'b0;
        end
        ST_DEVADDR, ST_WADDR, ST_WDATA: begin
          // [R2] Sample on rise
          if (scl_rise && link_reg.cnt < WORD_BITS) begin
            link_next.sh = {link_reg.sh[6:0], sda_f};
            link_next.cnt = 4'(link_reg.cnt + 4'h1);
          end else if (scl_fall && link_reg.cnt == WORD_BITS) begin
            // [R11] Ack in ninth clock
            link_next.oe = 1'b1;
            if (link_reg.st == ST_DEVADDR) begin
              // [R14] [R15] [R16] [R17] [R18] [R21] [R22] Address compare
              if (dev_match(link_reg.sh, strap_f, SIZE_SEL) && !link_reg.pend) begin
                // [R20] Direction bit
                link_next.rw = link_reg.sh[0];
                link_next.pg = page_hi(link_reg.sh, SIZE_SEL);
                link_next.st = ST_DEVACK;
              end else begin
                link_next.oe = 1'b0;
                link_next.st = ST_IDLE;
              end
            end else if (link_reg.st == ST_WADDR) begin
              // [R19] Page bits on top
              link_next.actr = ({link_reg.pg, 8'h00} | {3'h0, link_reg.sh})
                               & arr_mask(SIZE_SEL);
              link_next.st = ST_WAACK;
            end else begin
              // [R3] Write protect gate
              if (!wp_f) begin
                link_next.we = 1'b1;
                link_next.waddr = link_reg.actr;
                link_next.wd = link_reg.sh;
                link_next.dirty = 1'b1;
              end
              // [R23] Counter roll in page
              link_next.actr = next_addr(link_reg.actr, 1'b1, SIZE_SEL);
              link_next.st = ST_WDACK;
            end
          end
        end
        ST_DEVACK: begin
          // The acknowledge ends at the fall of the ninth clock.
          if (scl_fall) begin
            link_next.cnt = 4'h0;
            if (link_reg.rw) begin
              // [R2] Shift out on fall
              link_next.sh = rd_byte;
              link_next.oe = !rd_byte[7];
              link_next.st = ST_RDATA;
            end else begin
              link_next.oe = 1'b0;
              link_next.sh = 8'h00;
              link_next.st = ST_WADDR;
            end
          end
        end
        ST_WAACK, ST_WDACK: begin
          // Release the line and take the next data word.
          if (scl_fall) begin
            link_next.oe = 1'b0;
            link_next.cnt = 4'h0;
            link_next.sh = 8'h00;
            link_next.st = ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            link_next.cnt = 4'(link_reg.cnt + 4'h1);
          end else if (scl_fall) begin
            if (link_reg.cnt == WORD_BITS) begin
              // Release for the controller's acknowledge.
              link_next.oe = 1'b0;
              // [R23] Counter roll over array
              link_next.actr = next_addr(link_reg.actr, 1'b0, SIZE_SEL);
              link_next.st = ST_RACK;
            end else begin
              // [R1] Only pull low
              link_next.sh = {link_reg.sh[6:0], 1'b0};
              link_next.oe = !link_reg.sh[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            link_next.acked = !sda_f;
          end else if (scl_fall) begin
            if (link_reg.acked) begin
              link_next.sh = rd_byte;
              link_next.oe = !rd_byte[7];
              link_next.cnt = 4'h0;
              link_next.st = ST_RDATA;
            end else begin
              // [R10] No ack ends read
              link_next.oe = 1'b0;
              link_next.st = ST_IDLE;
            end
          end
        end
        default: begin
          link_next.oe = 1'b0;
          link_next.st = ST_IDLE;
        end
      endcase
    end
    // [R12] Standby when idle
    link_next.stby = (link_next.st == ST_IDLE) && !link_next.pend;
  end

  // Register the link state.
  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      link_reg <= '0;
      link_reg.st <= ST_IDLE;
      link_reg.scl_q <= LINE_IDLE;
      link_reg.sda_q <= LINE_IDLE;
      link_reg.stby <= STANDBY_RST;
    end else begin
      link_reg <= link_next;
    end
  end

  // Array write port; contents survive a link reset like stored data.
  always_ff @(posedge link_clk) begin
    if (link_reg.we) begin
      mem[link_reg.waddr] <= link_reg.wd;
    end
  end

  assign sda_o = link_reg.lvl;
  assign sda_oe = link_reg.oe;
  assign standby = link_reg.stby;

  // ==========================================================================
  // System domain write cycle timer

  typedef struct packed {
    logic tgl_q;
    logic busy;
    logic [16:0] cnt;
  } sepfe_sys_s;

  sepfe_sys_s sys_reg;
  sepfe_sys_s sys_next;

  // The commit toggle crosses as a level, so no event is lost.
  sepfe_sync #(.W(1), .RST_VAL(1'b0)) u_sync_tgl (
    .clk(sys_clk),
    .rst_n(rst_n),
    .d(link_reg.wr_tgl),
    .q(tgl_f)
  );

  // The busy level goes back to the link through the same kind of chain.
  sepfe_sync #(.W(1), .RST_VAL(1'b0)) u_sync_busy (
    .clk(link_clk),
    .rst_n(link_rst_n),
    .d(sys_reg.busy),
    .q(busy_f)
  );

  // [R22] Time the write cycle
  always_comb begin
    sys_next = sys_reg;
    sys_next.tgl_q = tgl_f;
    if (sys_reg.busy) begin
      if (sys_reg.cnt >= 17'(TWR_CYC - 1)) begin
        sys_next.busy = 1'b0;
      end
      sys_next.cnt = 17'(sys_reg.cnt + 17'h00001);
    end
    // A new commit restarts the timer and wins over its end.
    if (tgl_f != sys_reg.tgl_q) begin
      sys_next.busy = 1'b1;
      sys_next.cnt = 17'h00000;
    end
  end

  // Register the timer state.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sys_reg <= '0;
    end else begin
      sys_reg <= sys_next;
    end
  end

endmodule

`default_nettype wire

/* File: tb/sepfe_properties.sv */
// Purpose: Concurrent checks on the ports of the bus front end.
// Assumes: All checks sample on the link clock.
// Notes: Bound to the top module from the bench.
`timescale 1ns/100ps
`default_nettype none
// ============================================================================
// Checker
module sepfe_properties
  import sepfe_pkg::*;
#(
  parameter logic [1:0] SIZE_SEL = SZ_16K,
  parameter int unsigned TWR_CYC = TWR_CYCLES
) (
  // Clocks and resets
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic link_rst_n,
  // Bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  // Straps, protection and status
  input wire logic [2:0] chip_select_straps,
  input wire logic wp_i,
  input wire logic standby
);
  // Longest idle bus time with standby low, in link cycles.
  localparam int IDLE_LIM = 2 * TWR_CYC + 40;
  logic [31:0] idle_reg;

  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!link_rst_n);

  // Counts link cycles of an idle bus while standby is low.
  always_ff @(posedge link_clk) begin
    if (!link_rst_n || !scl_i || !sda_i || standby) begin
      idle_reg <= '0;
    end else begin
      idle_reg <= idle_reg + 32'h1;
    end
  end

  // Bus events seen at the pins.
  sequence s_scl_fall;
    $fell(scl_i);
  endsequence
  sequence s_start;
    scl_i && $fell(sda_i);
  endsequence

  chk_drive_low_only: assert property (sda_o == 1'b0)
    else $error("data line driven high");
  chk_reset_idle: assert property (disable iff (1'b0) !link_rst_n |=> !sda_oe && standby)
    else $error("not idle after reset");
  chk_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("data drive changed with clock high");
  chk_oe_filtered: assert property (s_scl_fall |=> $stable(sda_oe)[*2])
    else $error("data drive reacted before filtering");
  chk_oe_holds: assert property ($rose(sda_oe) |=> sda_oe[*4])
    else $error("data pull too short");
  chk_standby_free: assert property (standby |-> !sda_oe)
    else $error("data pulled in standby");
  chk_start_wakes: assert property (s_start |-> ##[1:8] !standby)
    else $error("start not taken");
  chk_idle_bound: assert property (idle_reg <= 32'(IDLE_LIM))
    else $error("standby not resumed on idle bus");
endmodule
`default_nettype wire

/* File: tb/sepfe_bus_ctrl.sv */
// Purpose: Behavioural two-wire bus controller driving the front end.
// Assumes: Quarter bit time of five system clocks (250 ns).
// Notes: The data line is only pulled low; the bench resolves the wire.
`timescale 1ns/100ps
`default_nettype none
// ============================================================================
// Bus controller
module sepfe_bus_ctrl (
  // Clock
  input wire logic clk,
  // Bus lines
  output logic scl_o,
  output logic sda_low,
  input wire logic sda_i
);
  localparam int QTR = 5;

  // Bus starts idle with both lines released.
  initial begin
    scl_o = 1'b1;
    sda_low = 1'b0;
  end

  // Waits a quarter bit time.
  task automatic wq();
    repeat (QTR) @(posedge clk);
  endtask

  task automatic bit_x(input logic b, output logic r);
    sda_low <= !b;
    wq();
    scl_o <= 1'b1;
    wq();
    r = sda_i;
    wq();
    scl_o <= 1'b0;
    wq();
  endtask

  task automatic bus_start();
    sda_low <= 1'b0;
    wq();
    scl_o <= 1'b1;
    wq();
    sda_low <= 1'b1;
    wq();
    scl_o <= 1'b0;
    wq();
  endtask

  // Stop: data rises while the clock is high.
  task automatic bus_stop();
    sda_low <= 1'b1;
    wq();
    scl_o <= 1'b1;
    wq();
    sda_low <= 1'b0;
    wq();
  endtask

  // Sends a word MSB first and returns the acknowledge.
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask

  // Receives a word, then acknowledges or not.
  task automatic rbyte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(!ack, r);
  endtask

  task automatic recover();
    logic r;
    for (int i = 0; i < 9; i++) bit_x(1'b1, r);
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench of the bus front end, 8K variant.
// Assumes: Straps tied to 101; only the upper one is compared.
// Notes: Write cycle shortened to 400 system clocks.
`timescale 1ns/100ps
`default_nettype none
`define CHECK(a, e) begin check_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
// ============================================================================
// Bench
module tb_top
  import sepfe_pkg::*;
;
  logic sys_clk = 1'b0;
  logic link_clk = 1'b1;
  logic rst_n;
  logic link_rst_n;
  logic wp;
  logic scl;
  logic ctrl_low;
  logic sda_o;
  logic sda_oe;
  logic standby;
  wire logic sda_w;
  int error_cnt;
  int check_count;

  // Clocks of unrelated phase.
  // The link clock starts high, so its rising edges never meet those of the system clock.
  always #25 sys_clk = ~sys_clk;
  always #15 link_clk = ~link_clk;

  // Open-drain wire with pull-up.
  assign sda_w = ctrl_low ? 1'b0 : (sda_oe ? sda_o : 1'b1);

  sepfe_top #(.SIZE_SEL(SZ_8K), .TWR_CYC(400)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .link_clk(link_clk), .link_rst_n(link_rst_n), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe(sda_oe), .chip_select_straps(3'h5), .wp_i(wp),
    .standby(standby));
  sepfe_bus_ctrl i_ctrl (.clk(sys_clk), .scl_o(scl), .sda_low(ctrl_low), .sda_i(sda_w));

  task automatic end_sim();
    $display("checks=%0d errors=%0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic send(input logic [7:0] b, input logic exp_ack);
    logic a;
    i_ctrl.wbyte(b, a);
    `CHECK(a, exp_ack)
  endtask

  task automatic recv(input logic [7:0] e, input logic ack);
    logic [7:0] d;
    i_ctrl.rbyte(ack, d);
    `CHECK(d, e)
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (standby !== 1'b1 && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    `CHECK(standby, 1'b1)
  endtask

  // Random read of two bytes at word 0x34 of the page that write word dw selects.
  task automatic rread(input logic [7:0] dw, input logic [7:0] e0, input logic [7:0] e1);
    i_ctrl.bus_start();
    send(dw, 1'b1);
    send(8'h34, 1'b1);
    i_ctrl.bus_start();
    send(8'had, 1'b1);
    recv(e0, 1'b1);
    recv(e1, 1'b0);
    i_ctrl.bus_stop();
  endtask

  task automatic t_reset();
    `CHECK(standby, 1'b1)
    `CHECK(sda_oe, 1'b0)
    $display("test reset done");
  endtask

  // Page write of two bytes, then a poll during the write cycle.
  task automatic t_write();
    i_ctrl.bus_start();
    send(8'hac, 1'b1);
    send(8'h34, 1'b1);
    send(8'h5a, 1'b1);
    send(8'hc3, 1'b1);
    i_ctrl.bus_stop();
    repeat (20) @(posedge sys_clk);
    `CHECK(standby, 1'b0)
    i_ctrl.bus_start();
    send(8'hac, 1'b0);
    i_ctrl.bus_stop();
    wait_idle();
    $display("test write done");
  endtask

  // Bytes written at the same word of page 00 must not land on page 10.
  task automatic t_read();
    rread(8'hac, 8'h5a, 8'hc3);
    repeat (20) @(posedge sys_clk);
    `CHECK(standby, 1'b1)
    i_ctrl.bus_start();
    send(8'ha8, 1'b1);
    send(8'h34, 1'b1);
    send(8'h96, 1'b1);
    send(8'h69, 1'b1);
    i_ctrl.bus_stop();
    wait_idle();
    rread(8'ha8, 8'h96, 8'h69);
    rread(8'hac, 8'h5a, 8'hc3);
    $display("test read done");
  endtask

  // Protected write is acknowledged but leaves the array unchanged.
  task automatic t_wp();
    wp <= 1'b1;
    i_ctrl.bus_start();
    send(8'hac, 1'b1);
    send(8'h34, 1'b1);
    send(8'hff, 1'b1);
    i_ctrl.bus_stop();
    wait_idle();
    wp <= 1'b0;
    rread(8'hac, 8'h5a, 8'hc3);
    $display("test protect done");
  endtask

  // Strap mismatch, wrong type, wrong type with matching strap.
  task automatic t_refuse();
    logic [7:0] words [3];
    words = '{8'ha4, 8'hbc, 8'h2c};
    foreach (words[i]) begin
      i_ctrl.bus_start();
      send(words[i], 1'b0);
      i_ctrl.bus_stop();
      repeat (20) @(posedge sys_clk);
      `CHECK(standby, 1'b1)
    end
    $display("test refuse done");
  endtask

  // Abort in mid-word, recover, then a full read.
  task automatic t_recover();
    logic r;
    i_ctrl.bus_start();
    send(8'hac, 1'b1);
    for (int i = 0; i < 4; i++) i_ctrl.bit_x(1'b1, r);
    i_ctrl.recover();
    rread(8'hac, 8'h5a, 8'hc3);
    $display("test recover done");
  endtask

  // Main sequence.
  initial begin
    rst_n = 1'b0;
    link_rst_n = 1'b0;
    wp = 1'b0;
    error_cnt = 0;
    check_count = 0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge link_clk);
    link_rst_n <= 1'b1;
    repeat (10) @(posedge sys_clk);
    t_reset();
    t_write();
    t_read();
    t_wp();
    t_refuse();
    t_recover();
    end_sim();
  end

  // Watchdog against a hang.
  initial begin
    repeat (40000) @(posedge sys_clk);
    error_cnt++;
    end_sim();
  end
endmodule

bind sepfe_top sepfe_properties #(.SIZE_SEL(SIZE_SEL), .TWR_CYC(TWR_CYC)) i_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk), .link_rst_n(link_rst_n),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .chip_select_straps(chip_select_straps), .wp_i(wp_i), .standby(standby));
`default_nettype wire
